/* File: shared/dcc_pkg.sv */
// constants and types shared by the dual capture/compare array
package dcc_pkg;
    localparam int NUM_UNITS   = 2;
    localparam int CH_PER_UNIT = 16;
    localparam int NUM_CH      = NUM_UNITS * CH_PER_UNIT;
    localparam int NUM_TMR     = NUM_UNITS * 2;
    localparam int TW          = 16;
    localparam int MODE_W      = 3;
    localparam int SRC_W       = 2;
    localparam int PRE_W       = 3;
    localparam int PRE_CNT_W   = 10;
    localparam int ADDR_W      = 5;
    // partner of a double-register pair sits this many channels higher
    localparam int DBL_OFS     = 8;
    localparam int EDGE_RISE   = 0;
    localparam int EDGE_FALL   = 1;
    localparam logic [TW-1:0]        TMR_MAX   = 16'hffff;
    localparam logic [TW-1:0]        TMR_RST   = 16'h0000;
    localparam logic [TW-1:0]        CCR_RST   = 16'h0000;
    localparam logic [PRE_CNT_W-1:0] PRE_ONES  = 10'h3ff;
    localparam logic [PRE_W-1:0]     PRE_LAST  = 3'h7;

    typedef enum logic [MODE_W-1:0] {
        MODE_OFF = 3'b000,
        MODE_CAP = 3'b001,
        MODE_C0  = 3'b010,
        MODE_C1  = 3'b011,
        MODE_C2  = 3'b100,
        MODE_C3  = 3'b101,
        MODE_DBL = 3'b110
    } dcc_mode_t;

    typedef enum logic [SRC_W-1:0] {
        SRC_PRE  = 2'b00,
        SRC_GPT  = 2'b01,
        SRC_EXT  = 2'b10,
        SRC_STOP = 2'b11
    } dcc_src_t;
endpackage

/* File: hw/dcc_top.sv */
// dual capture/compare array: two units of sixteen channels and two timers each
// Behaviour
// - two units, sixteen channels each
// - two reloadable 16-bit timers per unit
// - timer clock: prescaled clock or GPT overflow
// - first timer also counts external input
// - per-channel timer choice and capture/compare
// - one pin per channel, input or output
// - capture copies assigned timer on pin event
// - capture raises that channel's interrupt
// - capture edge: rising, falling or both
// - compare channels match timer after each timer step
// - mode 0: interrupt every match, pin unchanged
// - mode 1: pin toggles every match
// - mode 2: one interrupt per period
// - mode 3: set on match, clear on overflow
// - double mode: two registers toggle one pin
// - prescale codes select divisors 8 to 1024
// - reload 0000h gives 65536-tick period
`timescale 1ns/1ps
module dcc_top
(
    // clock and reset
    input  wire logic                                   I_CLK,
    input  wire logic                                   I_SRST,
    // time-base configuration, one slice per timer
    input  wire logic [dcc_pkg::NUM_TMR-1:0]            I_TMR_RUN,
    input  wire logic [dcc_pkg::NUM_TMR*dcc_pkg::SRC_W-1:0] I_TMR_SRC,
    input  wire logic [dcc_pkg::NUM_TMR*dcc_pkg::PRE_W-1:0] I_TMR_PRE,
    input  wire logic [dcc_pkg::NUM_TMR*dcc_pkg::TW-1:0]    I_TMR_RELOAD,
    // count events from outside
    input  wire logic                                   I_GPT_OVF,
    input  wire logic [dcc_pkg::NUM_UNITS-1:0]          I_EXT_CNT,
    // channel configuration
    input  wire logic [dcc_pkg::NUM_CH*dcc_pkg::MODE_W-1:0] I_CH_MODE,
    input  wire logic [dcc_pkg::NUM_CH-1:0]             I_CH_TSEL,
    input  wire logic [dcc_pkg::NUM_CH*2-1:0]           I_CH_EDGE,
    // register access
    input  wire logic                                   I_CCR_WE,
    input  wire logic [dcc_pkg::ADDR_W-1:0]             I_CCR_ADDR,
    input  wire logic [dcc_pkg::TW-1:0]                 I_CCR_WDATA,
    output logic      [dcc_pkg::TW-1:0]                 O_CCR_RDATA,
    // channel pins
    input  wire logic [dcc_pkg::NUM_CH-1:0]             I_CC_PIN,
    output logic      [dcc_pkg::NUM_CH-1:0]             O_CC_PIN,
    output logic      [dcc_pkg::NUM_CH-1:0]             O_CC_OE,
    // events and state
    output logic      [dcc_pkg::NUM_CH-1:0]             O_CC_IRQ,
    output logic      [dcc_pkg::NUM_TMR*dcc_pkg::TW-1:0] O_TMR_VAL,
    output logic      [dcc_pkg::NUM_TMR-1:0]            O_TMR_OVF
);
    import dcc_pkg::*;

    logic [PRE_CNT_W-1:0] pre_q;
    logic [NUM_UNITS-1:0] ext_q;
    logic [TW-1:0]        tmr_q [NUM_TMR];
    logic [NUM_TMR-1:0]   upd_q;
    logic [NUM_TMR-1:0]   tick_w;
    logic [TW-1:0]        ccr_q [NUM_CH];
    logic [TW-1:0]        tv_w  [NUM_CH];
    logic [NUM_CH-1:0]    pin_in_q;
    logic [NUM_CH-1:0]    done_q;
    logic [NUM_CH-1:0]    fire_w;
    logic [NUM_CH-1:0]    cap_w;
    logic [NUM_CH-1:0]    tovf_w;
    logic [NUM_CH-1:0]    dbl_hit;
    logic [TW-1:0]        rdata_q;

    wire [NUM_UNITS-1:0] ext_rise = I_EXT_CNT & ~ext_q;

    // one shared prescaler; each timer taps it through its own mask
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            pre_q <= '0;
            ext_q <= '0;
            rdata_q <= CCR_RST;
        end
        else
        begin
            pre_q <= pre_q + 10'h001;
            ext_q <= I_EXT_CNT;
            rdata_q <= ccr_q[I_CCR_ADDR];
        end
    end
    assign O_CCR_RDATA = rdata_q;

    genvar t, c;
    generate
        for (t = 0; t < NUM_TMR; t++)
        begin : g_tmr
            wire [PRE_W-1:0]     pre_sel  = I_TMR_PRE[t*PRE_W +: PRE_W];
            wire [PRE_CNT_W-1:0] pre_mask = PRE_ONES >> (PRE_LAST - pre_sel);
            wire                 pre_tick = (pre_q & pre_mask) == pre_mask;
            wire [SRC_W-1:0]     src      = I_TMR_SRC[t*SRC_W +: SRC_W];
            wire                 ext_ok   = (t % 2 == 0) && ext_rise[t/2];
            wire [TW-1:0]        reload   = I_TMR_RELOAD[t*TW +: TW];
            wire                 wrap     = tick_w[t] && (tmr_q[t] == TMR_MAX);
            wire [TW-1:0]        tmr_d    = wrap ? reload : TW'(tmr_q[t] + 16'h0001);
            assign tick_w[t] = I_TMR_RUN[t] && ((src == SRC_PRE && pre_tick)
                || (src == SRC_GPT && I_GPT_OVF) || (src == SRC_EXT && ext_ok));
            always_ff @(posedge I_CLK)
            begin
                if (I_SRST)
                begin
                    tmr_q[t] <= TMR_RST;
                    upd_q[t] <= 1'b0;
                    O_TMR_OVF[t] <= 1'b0;
                end
                else
                begin
                    if (tick_w[t])
                        tmr_q[t] <= tmr_d;
                    upd_q[t] <= tick_w[t];
                    O_TMR_OVF[t] <= wrap;
                end
            end
            assign O_TMR_VAL[t*TW +: TW] = tmr_q[t];
        end

        for (c = 0; c < NUM_CH; c++)
        begin : g_ch
            localparam int U = c / CH_PER_UNIT;
            localparam int K = c % CH_PER_UNIT;
            localparam int P = (K < DBL_OFS) ? c + DBL_OFS : c;
            wire [MODE_W-1:0] mode  = I_CH_MODE[c*MODE_W +: MODE_W];
            wire              tsel  = I_CH_TSEL[c];
            wire              tupd  = upd_q[U*2 + int'(tsel)];
            wire              is_c  = mode >= MODE_C0 && mode <= MODE_DBL;
            wire              once  = mode == MODE_C2 || mode == MODE_C3;
            wire              match = is_c && tupd && tv_w[c] == ccr_q[c];
            wire              rise  = I_CC_PIN[c] && !pin_in_q[c];
            wire              fall  = !I_CC_PIN[c] && pin_in_q[c];
            wire              we    = I_CCR_WE && I_CCR_ADDR == ADDR_W'(c);
            wire              tog   = (fire_w[c] && mode == MODE_C1)
                || (K < DBL_OFS && (dbl_hit[c] || dbl_hit[P]));
            wire              drv   = mode == MODE_C1 || mode == MODE_C3
                || (mode == MODE_DBL && K < DBL_OFS);

            assign tv_w[c]    = tmr_q[U*2 + int'(tsel)];
            assign tovf_w[c]  = O_TMR_OVF[U*2 + int'(tsel)];
            assign cap_w[c]   = mode == MODE_CAP
                && ((I_CH_EDGE[c*2 + EDGE_RISE] && rise) || (I_CH_EDGE[c*2 + EDGE_FALL] && fall));
            // the overflow cycle opens a new period, so an old done flag must not block it
            assign fire_w[c]  = match && !(once && done_q[c] && !tovf_w[c]);
            assign dbl_hit[c] = fire_w[c] && mode == MODE_DBL;

            always_ff @(posedge I_CLK)
            begin
                if (I_SRST)
                begin
                    ccr_q[c]    <= CCR_RST;
                    pin_in_q[c] <= 1'b0;
                    done_q[c]   <= 1'b0;
                    O_CC_IRQ[c] <= 1'b0;
                    O_CC_PIN[c] <= 1'b0;
                    O_CC_OE[c]  <= 1'b0;
                end
                else
                begin
                    pin_in_q[c] <= I_CC_PIN[c];
                    O_CC_OE[c]  <= drv;
                    O_CC_IRQ[c] <= cap_w[c] || fire_w[c];
                    // a capture wins over a software write in the same cycle
                    if (cap_w[c])
                        ccr_q[c] <= tv_w[c];
                    else if (we)
                        ccr_q[c] <= I_CCR_WDATA;
                    // a match in the overflow cycle already belongs to the new period
                    if (fire_w[c] && once)
                        done_q[c] <= 1'b1;
                    else if (tovf_w[c])
                        done_q[c] <= 1'b0;
                    if (mode == MODE_C3 && fire_w[c])
                        O_CC_PIN[c] <= 1'b1;
                    else if (mode == MODE_C3 && tovf_w[c])
                        O_CC_PIN[c] <= 1'b0;
                    else if (tog)
                        O_CC_PIN[c] <= !O_CC_PIN[c];
                end
            end
        end
    endgenerate

    // capture checks on channel 0, compare checks on channels 1 to 5 and 13, timer 0
    wire [MODE_W-1:0] m0  = I_CH_MODE[MODE_W-1:0];
    wire [MODE_W-1:0] m1  = I_CH_MODE[1*MODE_W +: MODE_W];
    wire [MODE_W-1:0] m2  = I_CH_MODE[2*MODE_W +: MODE_W];
    wire [MODE_W-1:0] m3  = I_CH_MODE[3*MODE_W +: MODE_W];
    wire [MODE_W-1:0] m4  = I_CH_MODE[4*MODE_W +: MODE_W];
    wire [MODE_W-1:0] m5  = I_CH_MODE[5*MODE_W +: MODE_W];
    wire [MODE_W-1:0] m13 = I_CH_MODE[13*MODE_W +: MODE_W];

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SRST);

    a_capture_takes_timer: assert property (cap_w[0] |=> ccr_q[0] == $past(tv_w[0]))
        else $error("capture did not latch timer");
    a_capture_irq_pulse: assert property (cap_w[0] |=> O_CC_IRQ[0])
        else $error("capture irq missing");
    a_edge_rise_only: assert property ((m0 == MODE_CAP && I_CH_EDGE[1:0] == 2'b01
        && !I_CC_PIN[0] && pin_in_q[0]) |-> !cap_w[0])
        else $error("falling edge captured in rise-only");
    a_mode0_irq_hold: assert property ((fire_w[2] && m2 == MODE_C0)
        |=> O_CC_IRQ[2] && $stable(O_CC_PIN[2]))
        else $error("mode 0 match wrong");
    a_mode1_toggles: assert property ((fire_w[1] && m1 == MODE_C1)
        |=> O_CC_PIN[1] != $past(O_CC_PIN[1]))
        else $error("mode 1 pin did not toggle");
    a_mode2_once: assert property ((m3 == MODE_C2 && done_q[3] && !tovf_w[3])
        |=> !O_CC_IRQ[3])
        else $error("second mode 2 irq in period");
    a_mode3_set: assert property ((fire_w[4] && m4 == MODE_C3) |=> O_CC_PIN[4])
        else $error("mode 3 pin not set");
    a_mode3_clear: assert property ((m4 == MODE_C3 && tovf_w[4] && !fire_w[4])
        |=> !O_CC_PIN[4])
        else $error("mode 3 pin not cleared");
    a_double_toggle: assert property ((dbl_hit[13] && m5 == MODE_DBL && !dbl_hit[5])
        |=> O_CC_PIN[5] != $past(O_CC_PIN[5]))
        else $error("double mode partner did not toggle");
    a_timer_wrap: assert property ((tick_w[0] && tmr_q[0] == TMR_MAX)
        |=> O_TMR_OVF[0] && tmr_q[0] == $past(I_TMR_RELOAD[TW-1:0]))
        else $error("timer did not reload");
    a_timer_step: assert property ((tick_w[0] && tmr_q[0] != TMR_MAX)
        |=> tmr_q[0] == TW'($past(tmr_q[0]) + 16'h0001))
        else $error("timer did not increment");
    a_prescale_eight: assert property ((tick_w[0] && I_TMR_SRC[1:0] == SRC_PRE
        && I_TMR_PRE[2:0] == 3'h0) |=> !tick_w[0] [*7] ##1 (tick_w[0] || I_TMR_PRE[2:0] != 3'h0))
        else $error("divide-by-8 spacing wrong");

    c_capture: cover property (cap_w[0]);
    c_mode3_match: cover property (fire_w[4] && m4 == MODE_C3);
    c_double_pair: cover property (dbl_hit[13] && m13 == MODE_DBL);
endmodule // dcc_top

/* File: tb/dcc_far_model.sv */
// far-side model: overflow pulses of the second general timer module and external counts
`timescale 1ns/1ps
module dcc_far_model
(
    // clock
    input  wire logic       i_clk,
    // source enables
    input  wire logic       i_gpt_en,
    input  wire logic [1:0] i_ext_en,
    // count events
    output logic            o_gpt_ovf,
    output logic [1:0]      o_ext_cnt
);
    initial o_gpt_ovf = 1'b0;
    initial o_ext_cnt = 2'b00;
    // one overflow a cycle is the fastest rate, so one rising count edge every two cycles
    always @(posedge i_clk)
    begin
        o_gpt_ovf <= #1 i_gpt_en;
        o_ext_cnt <= #1 o_ext_cnt ^ i_ext_en;
    end
endmodule // dcc_far_model

/* File: tb/dcc_top_test.sv */
// self-checking bench for the dual capture/compare array
`timescale 1ns/1ps
module dcc_top_test;
    import dcc_pkg::*;
    logic        clk, srst, we, gpt_en;
    logic [1:0]  ext_en;
    logic [3:0]  run;
    logic [7:0]  src;
    logic [11:0] pre;
    logic [63:0] rld, edg, tval;
    logic [95:0] mode;
    logic [31:0] tsel, pin, opin, oe, irq, po;
    logic [4:0]  addr;
    logic [15:0] wd, rd, v0;
    logic [3:0]  tovf;
    logic        gpt;
    logic [1:0]  ext;
    int          n_fail, checks, n, ev[6], tg[6];
    int          cc[6] = '{1, 2, 3, 4, 5, 13};
    dcc_mode_t   cm[6] = '{MODE_C1, MODE_C0, MODE_C2, MODE_C3, MODE_DBL, MODE_DBL};

    dcc_far_model i_dcc_far_model (.i_clk(clk), .i_gpt_en(gpt_en), .i_ext_en(ext_en),
        .o_gpt_ovf(gpt), .o_ext_cnt(ext));
    dcc_top i_dcc_top (.I_CLK(clk), .I_SRST(srst), .I_TMR_RUN(run), .I_TMR_SRC(src),
        .I_TMR_PRE(pre), .I_TMR_RELOAD(rld), .I_GPT_OVF(gpt), .I_EXT_CNT(ext),
        .I_CH_MODE(mode), .I_CH_TSEL(tsel), .I_CH_EDGE(edg), .I_CCR_WE(we),
        .I_CCR_ADDR(addr), .I_CCR_WDATA(wd), .O_CCR_RDATA(rd), .I_CC_PIN(pin),
        .O_CC_PIN(opin), .O_CC_OE(oe), .O_CC_IRQ(irq), .O_TMR_VAL(tval), .O_TMR_OVF(tovf));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // inputs move 1 ns after the edge so the design samples settled values
    task automatic tk(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        addr = a;
        wd = d;
        we = 1'b1;
        tk(1);
        we = 1'b0;
        tk(1);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        addr = a;
        tk(2);
        chk("ccr", 32'(e), 32'(rd));
    endtask

    function automatic int exp_tog(dcc_mode_t m, int p);
        case (m)
            MODE_C1: return p;
            MODE_C3, MODE_DBL: return 2 * p;
            default: return 0;
        endcase
    endfunction

    function automatic logic cap_hit(logic [1:0] code, logic rise);
        return rise ? code[EDGE_RISE] : code[EDGE_FALL];
    endfunction

    initial
    begin
        #(90000 * 100);
        n_fail++;
        close_out();
    end

    initial
    begin
        {we, gpt_en, ext_en, run, src, pre, rld, edg, mode, tsel, pin, addr, wd} = '0;
        srst = 1'b1;
        n_fail = 0;
        checks = 0;
        void'($urandom(33412));
        repeat (4) @(posedge clk);
        #1 srst = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            v0 = 16'($urandom);
            n = $urandom_range(31, 0);
            wr(n[4:0], v0);
            rdc(n[4:0], v0);
        end
        run[0] = 1'b1;
        for (int c = 0; c < 8; c++)
        begin
            pre[2:0] = c[2:0];
            tk(2);
            v0 = tval[15:0];
            tk(2 * (8 << c));
            chk("presc", 32'(v0 + 16'h2), 32'(tval[15:0]));
        end
        run[0] = 1'b0;
        src[7:4] = 4'ha;
        run[3:2] = 2'b11;
        ext_en = 2'b10;
        n = $urandom_range(12, 3);
        tk(4);
        v0 = tval[47:32];
        tk(2 * n);
        chk("ext", 32'(v0 + n[15:0]), 32'(tval[47:32]));
        chk("ext2", 32'h0, 32'(tval[63:48]));
        ext_en = 2'b00;
        run[3:2] = 2'b00;
        tk(2);
        // timers stand still here, so every capture must return the same value
        for (int u = 0; u < 2; u++)
            for (int e = 1; e < 4; e++)
            begin
                n = u * 16;
                mode[n*3 +: 3] = MODE_CAP;
                edg[n*2 +: 2] = e[1:0];
                v0 = tval[u*32 +: 16];
                wr(n[4:0], 16'h0);
                for (int r = 1; r >= 0; r--)
                begin
                    pin[n] = r[0];
                    // the interrupt stands for one cycle only
                    tk(1);
                    chk("cap_irq", 32'(cap_hit(e[1:0], r[0])), 32'(irq[n]));
                    rdc(n[4:0], (cap_hit(e[1:0], 1'b1) || !r[0]) ? v0 : 16'h0);
                end
            end
        for (int i = 0; i < 6; i++)
        begin
            mode[cc[i]*3 +: 3] = cm[i];
            tsel[cc[i]] = 1'b1;
            if (i < 5)
                // fff0 would meet the overflow cycle, where a mode 3 match beats the clear
                v0 = 16'hfff0 | 16'($urandom_range(15, 1));
            wr(cc[i][4:0], (i == 5) ? v0 ^ 16'h8 : v0);
        end
        src[3:2] = SRC_GPT;
        rld[31:16] = 16'hfff0;
        run[1] = 1'b1;
        gpt_en = 1'b1;
        for (int w = 0; w < 2; w++)
        begin
            n = 0;
            do
            begin
                tk(1);
                n++;
            end
            while (tovf[1] !== 1'b1 && n < 70000);
            // first wrap includes one cycle of far-model lag
            chk("period", (w == 1) ? 32'd16 : 32'd65537, n);
            chk("reload", 32'hfff0, 32'(tval[31:16]));
        end
        ev = '{default: 0};
        tg = '{default: 0};
        for (int k = 0; k < 48; k++)
        begin
            po = opin;
            tk(1);
            for (int i = 0; i < 6; i++)
            begin
                ev[i] += int'(irq[cc[i]]);
                tg[i] += int'(opin[cc[i]] != po[cc[i]]);
            end
        end
        for (int i = 0; i < 6; i++)
        begin
            chk("cmp_irq", 32'd3, ev[i]);
            chk("cmp_tog", (i == 5) ? 0 : exp_tog(cm[i], 3), tg[i]);
        end
        chk("dbl_oe", 32'h20, oe & 32'h2020);
        close_out();
    end
endmodule // dcc_top_test
